/* pmx_pkg.sv */
// constants, opcodes and state type of the port move instruction executor
package pmx_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int NIB_W = 4;
   localparam int RAM_AW = 7;
   localparam int RAM_DEPTH = 128;
   localparam int WREG_AW = 4;
   localparam int INSTR_W = 16;
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam int IDX_W = 6;

   // ------------------------------------------------------------
   // register word indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_INSTR = 6'h00;
   localparam logic [IDX_W-1:0] IDX_STATUS = 6'h01;
   localparam logic [IDX_W-1:0] IDX_CONFIG = 6'h02;
   localparam logic [IDX_W-1:0] IDX_PORTS = 6'h03;
   localparam logic [IDX_W-1:0] IDX_WAKE = 6'h04;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int ST_ZF_BIT = 4;
   localparam int CFG_EMODE_BIT = 4;
   localparam int WK_FLAG_BIT = 4;
   localparam int PT_A_LSB = 0;
   localparam int PT_B_LSB = 4;
   localparam int PT_C_LSB = 8;
   localparam int PT_D_LSB = 12;
   localparam int PT_E_LSB = 16;
   localparam int PT_CIN_LSB = 20;

   // ------------------------------------------------------------
   // opcodes, matched against the upper bits of the word
   // ------------------------------------------------------------
   localparam logic [8:0] OP_IN_C = 9'h096;
   localparam logic [8:0] OP_IN_D = 9'h097;
   localparam logic [3:0] OP_WR_TO_RAM = 4'hF;
   localparam logic [4:0] OP_IMM_TO_RAM = 5'h17;
   localparam logic [8:0] OP_OUT_A = 9'h0B4;
   localparam logic [8:0] OP_OUT_B = 9'h0B5;
   localparam logic [8:0] OP_OUT_C = 9'h118;
   localparam logic [8:0] OP_OUT_D = 9'h119;
   localparam logic [7:0] OP_OUT_E = 8'h5C;
   localparam logic [11:0] OP_WAKE_MASK = 12'h520;

   // ------------------------------------------------------------
   // reset values and responses
   // ------------------------------------------------------------
   localparam logic [NIB_W-1:0] CDIR_RST = 4'hF;
   localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [IDX_W-1:0] widx;
      logic [INSTR_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [AXI_DW-1:0] rdata;
      logic [INSTR_W-1:0] last_instr;
      logic [NIB_W-1:0] acc;
      logic zero_flag;
      logic [NIB_W-1:0] port_a_output;
      logic [NIB_W-1:0] port_b_output;
      logic [NIB_W-1:0] port_c_latch;
      logic [NIB_W-1:0] port_d_latch;
      logic [NIB_W-1:0] internal_parallel_latch;
      logic [NIB_W-1:0] port_e_output;
      logic [NIB_W-1:0] port_c_direction_setting;
      logic [NIB_W-1:0] port_c_oe;
      logic port_e_mode_setting;
      logic [NIB_W-1:0] stop_wake_enable_mask;
      logic [NIB_W-1:0] port_c_prev;
      logic wake;
   } pmx_state_t;

   localparam pmx_state_t PMX_STATE_RST = '{
      awready: 1'b1,
      wready: 1'b1,
      arready: 1'b1,
      port_c_direction_setting: CDIR_RST,
      default: '0
   };

endpackage

/* pmx_ram.sv */
// data RAM of 4-bit words with one write port and two read ports
`timescale 1ns/1ps
`default_nettype none
module pmx_ram
   import pmx_pkg::*;
#(
   parameter int DEPTH = RAM_DEPTH,
   parameter int AW = RAM_AW,
   parameter int DW = NIB_W
) (
   // clock
   input wire logic aclk,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // addressed read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata,
   // working register read port, the lowest words of the array
   input wire logic [WREG_AW-1:0] wr_addr,
   output logic [DW-1:0] wr_rdata
);

   logic [DW-1:0] mem [DEPTH];

   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // reads are combinational so a move completes in one cycle
   assign rdata = mem[raddr];
   assign wr_rdata = mem[{{(AW-WREG_AW){1'b0}}, wr_addr}];

endmodule
`default_nettype wire

/* pmx_exec.sv */
// port move instruction executor with its AXI4-Lite register slave
// ------------------------------------------------------------
// Summary of operation
// [RULE1] input port C to accumulator and RAM, zero flag
// [RULE2] input port D to accumulator and RAM, zero flag
// [RULE3] copy working register into addressed RAM word
// [RULE4] write immediate nibble into addressed RAM word
// [RULE5] addressed RAM word to port A latch
// [RULE6] addressed RAM word to port B latch
// [RULE7] addressed RAM word to port C latch
// [RULE8] addressed RAM word to port D latch
// [RULE9] addressed RAM word to port E latch
// [RULE10] load wake mask; enabled falling edges wake
// [RULE11] mask bit n serves port C pin n
// [RULE12] port C direction per pin, reset all input
// [RULE13] port E shows latch or serial output
// [RULE14] edges on masked-off pins never wake
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pmx_exec
   import pmx_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [AXI_DW-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [AXI_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [AXI_DW-1:0] rdata,
   output logic [1:0] rresp,
   // output ports a, b, d
   output logic [NIB_W-1:0] port_a_output,
   output logic [NIB_W-1:0] port_b_output,
   output logic [NIB_W-1:0] port_d_out,
   input wire logic [NIB_W-1:0] port_d_in,
   // port c two-way pins
   input wire logic [NIB_W-1:0] port_c_in,
   output logic [NIB_W-1:0] port_c_out,
   output logic [NIB_W-1:0] port_c_oe,
   // port e and the serial unit that may own it
   input wire logic [NIB_W-1:0] serial_out,
   output logic [NIB_W-1:0] port_e_output,
   // stop mode wake-up
   input wire logic stop_mode,
   output logic stop_wake
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   pmx_state_t r;
   pmx_state_t n;

   logic ram_we;
   logic [RAM_AW-1:0] ram_waddr;
   logic [NIB_W-1:0] ram_wdata;
   logic [NIB_W-1:0] ram_rdata;
   logic [NIB_W-1:0] wr_rdata;
   logic [INSTR_W-1:0] instr;
   logic exec;
   logic [NIB_W-1:0] in_val;
   logic in_load;

   assign instr = r.wdata;

   pmx_ram #(
      .DEPTH(RAM_DEPTH),
      .AW(RAM_AW),
      .DW(NIB_W)
   ) u_ram (
      .aclk(aclk),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(ram_wdata),
      .raddr(instr[RAM_AW-1:0]),
      .rdata(ram_rdata),
      .wr_addr(instr[10:7]),
      .wr_rdata(wr_rdata)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      n = r;
      ram_we = 1'b0;
      ram_waddr = instr[RAM_AW-1:0];
      ram_wdata = NIB_ZERO;
      in_val = NIB_ZERO;
      in_load = 1'b0;
      exec = 1'b0;

      // write channels are taken in either order
      if (awvalid && r.awready) begin
         n.aw_got = 1'b1;
         n.awready = 1'b0;
         n.widx = awaddr[AXI_AW-1:2];
      end
      if (wvalid && r.wready) begin
         n.w_got = 1'b1;
         n.wready = 1'b0;
         n.wdata = wdata[INSTR_W-1:0];
         n.wstrb = wstrb;
      end

      if (r.aw_got && r.w_got) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         unique case (r.widx)
            IDX_INSTR: begin
               // a partial word cannot form an instruction
               exec = &r.wstrb[1:0];
            end
            IDX_CONFIG: begin
               if (r.wstrb[0]) begin
                  n.port_c_direction_setting = r.wdata[NIB_W-1:0]; // RULE12
                  n.port_e_mode_setting = r.wdata[CFG_EMODE_BIT];
               end
            end
            IDX_STATUS, IDX_PORTS, IDX_WAKE: begin
               n.bresp = RESP_OKAY;
            end
            default: begin
               n.bresp = RESP_SLVERR;
            end
         endcase
      end

      if (r.bvalid && bready) begin
         n.bvalid = 1'b0;
         n.awready = 1'b1;
         n.wready = 1'b1;
      end

      // ---------------------------------------------------------
      // instruction execution, one cycle each
      // ---------------------------------------------------------
      if (exec) begin
         n.last_instr = instr;
         if (instr[15:7] == OP_IN_C) begin
            in_val = port_c_in; // RULE1
            in_load = 1'b1;
         end else if (instr[15:7] == OP_IN_D) begin
            in_val = port_d_in; // RULE2
            in_load = 1'b1;
         end else if (instr[15:12] == OP_WR_TO_RAM) begin
            ram_we = 1'b1; // RULE3
            ram_wdata = wr_rdata;
         end else if (instr[15:11] == OP_IMM_TO_RAM) begin
            ram_we = 1'b1; // RULE4
            ram_wdata = instr[10:7];
         end else if (instr[15:7] == OP_OUT_A) begin
            n.port_a_output = ram_rdata; // RULE5
         end else if (instr[15:7] == OP_OUT_B) begin
            n.port_b_output = ram_rdata; // RULE6
         end else if (instr[15:7] == OP_OUT_C) begin
            n.port_c_latch = ram_rdata; // RULE7
         end else if (instr[15:7] == OP_OUT_D) begin
            n.port_d_latch = ram_rdata; // RULE8
         end else if (instr[15:8] == OP_OUT_E) begin
            n.internal_parallel_latch = ram_rdata; // RULE9
         end else if (instr[15:4] == OP_WAKE_MASK) begin
            n.stop_wake_enable_mask = instr[3:0]; // RULE10
         end
         if (in_load) begin
            // accumulator and RAM take the same sampled value
            n.acc = in_val;
            n.zero_flag = (in_val == NIB_ZERO);
            ram_we = 1'b1;
            ram_wdata = in_val;
         end
      end

      // ---------------------------------------------------------
      // read channel
      // ---------------------------------------------------------
      if (arvalid && r.arready) begin
         n.arready = 1'b0;
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         n.rdata = '0;
         unique case (araddr[AXI_AW-1:2])
            IDX_INSTR: begin
               n.rdata[INSTR_W-1:0] = r.last_instr;
            end
            IDX_STATUS: begin
               n.rdata[NIB_W-1:0] = r.acc;
               n.rdata[ST_ZF_BIT] = r.zero_flag;
            end
            IDX_CONFIG: begin
               n.rdata[NIB_W-1:0] = r.port_c_direction_setting;
               n.rdata[CFG_EMODE_BIT] = r.port_e_mode_setting;
            end
            IDX_PORTS: begin
               n.rdata[PT_A_LSB +: NIB_W] = r.port_a_output;
               n.rdata[PT_B_LSB +: NIB_W] = r.port_b_output;
               n.rdata[PT_C_LSB +: NIB_W] = r.port_c_latch;
               n.rdata[PT_D_LSB +: NIB_W] = r.port_d_latch;
               n.rdata[PT_E_LSB +: NIB_W] = r.internal_parallel_latch;
               n.rdata[PT_CIN_LSB +: NIB_W] = port_c_in;
            end
            IDX_WAKE: begin
               n.rdata[NIB_W-1:0] = r.stop_wake_enable_mask;
               n.rdata[WK_FLAG_BIT] = r.wake;
            end
            default: begin
               n.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (r.rvalid && rready) begin
         n.rvalid = 1'b0;
         n.arready = 1'b1;
      end

      // ---------------------------------------------------------
      // pins
      // ---------------------------------------------------------
      // direction bit one means input, so the driver is its inverse
      n.port_c_oe = ~n.port_c_direction_setting; // RULE12
      // serial mode hands the pins to the serial unit, latch is kept
      n.port_e_output = n.port_e_mode_setting ? serial_out
                                              : n.internal_parallel_latch; // RULE13
      // falling edge per pin, each gated by its own mask bit
      n.port_c_prev = port_c_in;
      n.wake = stop_mode &&
               |(r.stop_wake_enable_mask & r.port_c_prev & ~port_c_in); // RULE11 RULE14
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= PMX_STATE_RST;
      end else begin
         r <= n;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign awready = r.awready;
   assign wready = r.wready;
   assign bvalid = r.bvalid;
   assign bresp = r.bresp;
   assign arready = r.arready;
   assign rvalid = r.rvalid;
   assign rdata = r.rdata;
   assign rresp = r.rresp;
   assign port_a_output = r.port_a_output;
   assign port_b_output = r.port_b_output;
   assign port_d_out = r.port_d_latch;
   assign port_c_out = r.port_c_latch;
   assign port_c_oe = r.port_c_oe;
   assign port_e_output = r.port_e_output;
   assign stop_wake = r.wake;

endmodule
`default_nettype wire

/* pmx_exec_properties.sv */
// concurrent checks on the ports of the port move executor
`timescale 1ns/1ps
`default_nettype none
module pmx_exec_properties
   import pmx_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   // port latches and pins
   input wire logic [NIB_W-1:0] port_a_output,
   input wire logic [NIB_W-1:0] port_b_output,
   input wire logic [NIB_W-1:0] port_d_out,
   input wire logic [NIB_W-1:0] port_c_out,
   input wire logic [NIB_W-1:0] port_c_oe,
   input wire logic [NIB_W-1:0] port_c_in,
   // stop mode
   input wire logic stop_mode,
   input wire logic stop_wake
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_write_answer: assert property (
      awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
      else $error("write answer not two edges after handshake");
   a_bvalid_ends: assert property (
      bvalid && bready |=> !bvalid && awready && wready)
      else $error("write response not retired");
   a_read_answer: assert property (
      arvalid && arready |=> rvalid && !arready)
      else $error("read data not one edge after address");
   a_rvalid_ends: assert property (
      rvalid && rready |=> !rvalid && arready)
      else $error("read response not retired");
   a_bus_blocked: assert property (
      bvalid |-> !awready && !wready)
      else $error("new write taken while response pending");
   // latches may only move on the edge that executes an instruction
   a_latch_at_exec: assert property (
      $changed({port_a_output, port_b_output, port_d_out, port_c_out})
      |-> $rose(bvalid))
      else $error("port latch changed outside execution");
   a_oe_reset: assert property (
      $rose(aresetn) |-> port_c_oe == 4'h0)
      else $error("port c not all input after reset");
   a_wake_cause: assert property (
      stop_wake |-> $past(stop_mode)
      && (($past(port_c_in, 2) & ~$past(port_c_in)) != 4'h0))
      else $error("wake without a falling edge in stop mode");

   c_wake: cover property (stop_wake);
   c_write: cover property (bvalid && bready);
   c_read: cover property (rvalid && rready);
endmodule
`default_nettype wire

/* pmx_pins.sv */
// far-side pins: port c drivers, port d levels, serial unit drive
`timescale 1ns/1ps
`default_nettype none
module pmx_pins
   import pmx_pkg::*;
(
   // clock
   input wire logic aclk,
   // device side of port c
   input wire logic [NIB_W-1:0] port_c_out,
   input wire logic [NIB_W-1:0] port_c_oe,
   // levels the bench puts on the far side
   input wire logic [NIB_W-1:0] c_drive,
   input wire logic [NIB_W-1:0] d_drive,
   // resolved levels
   output logic [NIB_W-1:0] port_c_in,
   output logic [NIB_W-1:0] port_d_in,
   output logic [NIB_W-1:0] serial_out
);
   logic [NIB_W-1:0] cnt_r = 4'h0;
   // a pin the device drives shows its level, the others show ours
   assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & c_drive);
   assign port_d_in = d_drive;
   // changes every cycle so a stale copy on port e is visible
   always @(posedge aclk) cnt_r <= cnt_r + 4'h1;
   assign serial_out = cnt_r;
endmodule
`default_nettype wire

/* port_move_instruction_exec_bench.sv */
// self-checking bench for the port move instruction executor
`timescale 1ns/1ps
`default_nettype none
module port_move_instruction_exec_bench;
   import pmx_pkg::*;
   typedef struct packed {
      logic [15:0] ins;
      logic [3:0] c;
      logic [3:0] d;
      logic [5:0] idx;
      logic [23:0] msk;
      logic [23:0] exp;
   } pmx_row_t;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, stop_mode, stop_wake;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [23:0] got;
   logic [1:0] bresp, rresp, rs;
   logic [3:0] port_a_output, port_b_output, port_d_out, port_d_in;
   logic [3:0] port_c_in, port_c_out, port_c_oe, serial_out, port_e_output;
   logic [3:0] c_drive, d_drive, wstrb;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   int wakes = 0;
   int w0;
   pmx_row_t rows [11] = '{
      '{16'hBD05, 4'h0, 4'h0, IDX_PORTS, 24'h00_0000, 24'h00_0000},
      '{16'h5A05, 4'h0, 4'h0, IDX_PORTS, 24'h00_000F, 24'h00_000A},
      '{16'hBB03, 4'h0, 4'h0, IDX_PORTS, 24'h00_0000, 24'h00_0000},
      '{16'hF194, 4'h0, 4'h0, IDX_PORTS, 24'h00_0000, 24'h00_0000},
      '{16'h5A94, 4'h0, 4'h0, IDX_PORTS, 24'h00_00F0, 24'h00_0060},
      '{16'h4B21, 4'h9, 4'h0, IDX_STATUS, 24'h00_001F, 24'h00_0009},
      '{16'h8C21, 4'h9, 4'h0, IDX_PORTS, 24'h00_0F00, 24'h00_0900},
      '{16'h4BA2, 4'h9, 4'h0, IDX_STATUS, 24'h00_001F, 24'h00_0010},
      '{16'h8C85, 4'h9, 4'h0, IDX_PORTS, 24'h00_F000, 24'h00_A000},
      '{16'h5C14, 4'h9, 4'h0, IDX_PORTS, 24'h0F_0000, 24'h06_0000},
      '{16'h5205, 4'h9, 4'h0, IDX_WAKE, 24'h00_000F, 24'h00_0005}};

   pmx_exec u_pmx_exec (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .port_a_output(port_a_output),
      .port_b_output(port_b_output), .port_d_out(port_d_out),
      .port_d_in(port_d_in), .port_c_in(port_c_in), .port_c_out(port_c_out),
      .port_c_oe(port_c_oe), .serial_out(serial_out),
      .port_e_output(port_e_output), .stop_mode(stop_mode),
      .stop_wake(stop_wake));
   pmx_pins u_pmx_pins (.aclk(aclk), .port_c_out(port_c_out),
      .port_c_oe(port_c_oe), .c_drive(c_drive), .d_drive(d_drive),
      .port_c_in(port_c_in), .port_d_in(port_d_in), .serial_out(serial_out));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // the ceiling sits far above the roughly 120 cycles the run needs
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      wakes <= wakes + int'(stop_wake === 1'b1);
      if (cycles == 3000) begin
         fails++;
         close_out();
      end
   end

   task automatic chk_word(input logic [31:0] g, e, input string m);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic chk_pin(input logic [3:0] g, e, input string m);
      chk_word({28'h0, g}, {28'h0, e}, m);
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) aw_ok = 1'b1;
         if (wvalid && wready) w_ok = 1'b1;
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [5:0] i);
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode} = '0;
      {awaddr, araddr, wdata, c_drive, d_drive} = '0;
      wstrb = 4'hF;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (rows[i]) begin
         c_drive <= rows[i].c;
         d_drive <= rows[i].d;
         axi_wr(8'h00, {16'h0000, rows[i].ins});
         axi_rd(rows[i].idx);
         got = rd[23:0] & rows[i].msk;
         if (|rows[i].msk) chk_word({8'h00, got}, {8'h00, rows[i].exp},
            "table row");
      end
      chk_pin(port_a_output, 4'hA, "port a pins");
      chk_pin(port_b_output, 4'h6, "port b pins");
      chk_pin(port_c_out, 4'h9, "port c latch");
      chk_pin(port_d_out, 4'hA, "port d pins");
      chk_pin(port_e_output, 4'h6, "port e pins");
      // a single-byte strobe must not execute: the mask stays 0101
      wstrb <= 4'h1;
      axi_wr(8'h00, 32'h0000_520A);
      wstrb <= 4'hF;
      axi_rd(IDX_WAKE);
      chk_word(rd & 32'h0000_000F, 32'h0000_0005, "partial strobe");
      $display("test table done");
      // mask 0101: pins 0 and 2 wake, pin 1 must not
      stop_mode <= 1'b1;
      c_drive <= 4'hF;
      repeat (3) @(posedge aclk);
      w0 = wakes;
      foreach (rows[i]) if (i < 3) begin
         c_drive <= 4'hE << i;
         repeat (4) @(posedge aclk);
      end
      stop_mode <= 1'b0;
      c_drive <= 4'hF;
      repeat (3) @(posedge aclk);
      c_drive <= 4'h0;
      repeat (4) @(posedge aclk);
      chk_word(wakes - w0, 32'h0000_0002, "wake count");
      $display("test wake done");
      axi_wr(8'h08, 32'h0000_001A);
      repeat (3) @(posedge aclk);
      chk_pin(port_c_oe, 4'h5, "port c enables");
      chk_pin(port_e_output, serial_out - 4'h1, "port e serial");
      $display("test modes done");
      axi_wr(8'h3C, 32'h0000_0000);
      chk_pin({2'b00, rs}, {2'b00, RESP_SLVERR}, "unmapped write");
      axi_rd(6'h0F);
      chk_pin({2'b00, rs}, {2'b00, RESP_SLVERR}, "unmapped read");
      $display("test unmapped done");
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_pin(port_c_oe, 4'h0, "enables after reset");
      chk_pin(port_e_output, 4'h0, "port e after reset");
      axi_rd(IDX_CONFIG);
      chk_word(rd, 32'h0000_000F, "config after reset");
      $display("test reset done");
      close_out();
   end
endmodule

bind pmx_exec pmx_exec_properties u_pmx_exec_properties (.aclk(aclk),
   .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
   .port_a_output(port_a_output), .port_b_output(port_b_output),
   .port_d_out(port_d_out), .port_c_out(port_c_out), .port_c_oe(port_c_oe),
   .port_c_in(port_c_in), .stop_mode(stop_mode), .stop_wake(stop_wake));
`default_nettype wire
